// [common/itp_pkg.sv]
// Constants shared by the register port target logic and its data FIFO.
// Assumes SCL and SDA arrive as raw pin levels from outside the clock domain.
package itp_pkg;
   // ==========================================================
   // Address selection
   // ==========================================================
   // Version of the part: selects how the target address is formed.
   localparam logic [1:0] ITP_VER_TWO_SEL = 2'h0;
   localparam logic [1:0] ITP_VER_ONE_SEL = 2'h1;
   localparam logic [1:0] ITP_VER_FIXED = 2'h2;
   // Resolved three-level codes of a selection input.
   localparam logic [1:0] ITP_SEL_FLOAT = 2'h0;
   localparam logic [1:0] ITP_SEL_GND = 2'h1;
   localparam logic [1:0] ITP_SEL_SUPPLY = 2'h2;
   // Fixed leading bits and fixed address.
   localparam logic [2:0] ITP_ADDR_PREFIX = 3'h5;
   localparam logic [4:0] ITP_ADDR_ONE_PREFIX = 5'h14;
   localparam logic [6:0] ITP_ADDR_FIXED = 7'h54;
   // ==========================================================
   // Bus framing
   // ==========================================================
   // Upper five bits of the high-speed master code.
   localparam logic [4:0] ITP_MCODE_TOP = 5'h01;
   localparam logic [2:0] ITP_LAST_BIT = 3'h7;
   localparam int ITP_FIFO_DEPTH = 16;
   localparam int ITP_DATA_W = 8;
   // Bench link clock period, in ns, for reference by timing checks.
   localparam int ITP_LINK_PERIOD_NS = 125;
endpackage

// [core/itp_target.sv]
// Serial target port with its write-data FIFO, both in this file.
// Assumes a pulled-up bus, a resolved address selection and a 200 MHz sys_clk_i.
`timescale 1ns/100ps

// ==========================================================
// Write data FIFO
// ==========================================================
module itp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Filling side.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic full;
   logic empty;
   // Full when the pointers differ only in their wrap bit.
   assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty = (wp_r == rp_r);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[rp_r[AW-1:0]];
   // Pointers move on each accepted handshake.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid_i && !full) wp_r <= wp_r + 1'b1;
         if (out_ready_i && !empty) rp_r <= rp_r + 1'b1;
      end
   end
   // Storage has no reset; only valid words are ever read.
   always_ff @(posedge sys_clk_i) begin
      if (in_valid_i && !full) mem[wp_r[AW-1:0]] <= in_data_i;
   end
endmodule

// ==========================================================
// Target port
// ==========================================================
// What this block does
// - A falling data line while clock high starts an address phase.
// - Seven address bits and a direction bit arrive, then the target acknowledges.
// - Acknowledge a matching address; ignore the rest after a mismatch.
// - Acknowledge pulls data low; not-acknowledge releases it.
// - First written byte after the address loads the register pointer.
// - Upper then lower data bytes are written, each acknowledged.
// - A read sends the upper byte of the pointed register at once.
// - Controller acknowledge continues upper, lower, upper; not-acknowledge ends sending.
// - Reads continue without limit while the controller acknowledges.
// - A repeated start begins a new address phase, keeping speed mode.
// - A rising data line while clock high ends the transaction; idle.
// - The master code after a start is not acknowledged.
// - High speed survives repeated starts and ends at a stop.
// - Two-input address is 101, high code, low code.
// - One-input address is 10100 followed by the low code.
// - Version without selection inputs answers one fixed address.
// - Data line is only driven low; a one releases it.
module itp_target
   import itp_pkg::*;
#(
   parameter logic [1:0] VERSION = itp_pkg::ITP_VER_TWO_SEL
) (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Bus pins; data is open drain.
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Resolved address selection codes.
   input wire logic [1:0] addr_select_high_i,
   input wire logic [1:0] addr_select_low_i,
   // Register file side.
   output logic [7:0] pointer_o,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic [7:0] wr_data_o,
   output logic wr_upper_o,
   input wire logic [15:0] rd_data_i,
   output logic rd_upper_o,
   // Status.
   output logic hs_mode_o,
   output logic busy_o
);
   import itp_pkg::*;

   typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK,
                 ST_MCODE_NACK} itp_state_e;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_q;
      logic sda_q;
      itp_state_e st;
      logic [7:0] sh;
      logic [2:0] cnt;
      logic byte_done;
      logic is_rd;
      logic got_ptr;
      logic upper;
      logic hs;
      logic [6:0] addr;
      logic addr_ok;
      logic [7:0] ptr;
      logic drv_low;
      logic wr_v;
      logic [7:0] wr_d;
      logic wr_up;
   } itp_s;

   itp_s cur_r;
   itp_s cur_nxt;
   logic scl_v;
   logic sda_v;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] fifo_data;
   logic fifo_ready;
   logic fifo_out_v;

   // Target address from the version and the selection codes.
   function automatic logic [6:0] itp_addr(input logic [1:0] hi, input logic [1:0] lo);
      case (VERSION)
         ITP_VER_TWO_SEL: itp_addr = {ITP_ADDR_PREFIX, hi, lo};
         ITP_VER_ONE_SEL: itp_addr = {ITP_ADDR_ONE_PREFIX, lo};
         default: itp_addr = ITP_ADDR_FIXED;
      endcase
   endfunction

   // Filtered levels: stages two and three must agree before a change counts.
   always_comb begin
      scl_v = (cur_r.scl_s[1] == cur_r.scl_s[2]) ? cur_r.scl_s[2] : cur_r.scl_q;
      sda_v = (cur_r.sda_s[1] == cur_r.sda_s[2]) ? cur_r.sda_s[2] : cur_r.sda_q;
      scl_rise = scl_v && !cur_r.scl_q;
      scl_fall = !scl_v && cur_r.scl_q;
      start_c = scl_v && cur_r.scl_q && cur_r.sda_q && !sda_v;
      stop_c = scl_v && cur_r.scl_q && !cur_r.sda_q && sda_v;
   end

   // Protocol engine.
   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.scl_s = {cur_r.scl_s[1:0], scl_i};
      cur_nxt.sda_s = {cur_r.sda_s[1:0], sda_i};
      cur_nxt.scl_q = scl_v;
      cur_nxt.sda_q = sda_v;
      cur_nxt.wr_v = cur_r.wr_v && !fifo_ready;
      if (!cur_r.addr_ok) begin
         cur_nxt.addr = itp_addr(addr_select_high_i, addr_select_low_i);
         cur_nxt.addr_ok = 1'b1;
      end
      if (stop_c) begin
         cur_nxt.st = ST_IDLE;
         cur_nxt.hs = 1'b0;
         cur_nxt.drv_low = 1'b0;
      end else if (start_c) begin
         cur_nxt.st = ST_ADDR;
         cur_nxt.cnt = 3'h0;
         cur_nxt.byte_done = 1'b0;
         cur_nxt.drv_low = 1'b0;
      end else begin
         case (cur_r.st)
            ST_IDLE: begin
               cur_nxt.drv_low = 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  cur_nxt.sh = {cur_r.sh[6:0], sda_v};
                  cur_nxt.cnt = cur_r.cnt + 3'h1;
                  cur_nxt.byte_done = (cur_r.cnt == ITP_LAST_BIT);
               end
               // The fall right after a start carries no bit, so wait for a whole byte.
               if (scl_fall && cur_r.byte_done) begin
                  cur_nxt.byte_done = 1'b0;
                  if (cur_r.sh[7:3] == ITP_MCODE_TOP) begin
                     cur_nxt.st = ST_MCODE_NACK;
                  end else if (cur_r.sh[7:1] == cur_r.addr) begin
                     cur_nxt.st = ST_ADDR_ACK;
                     cur_nxt.is_rd = cur_r.sh[0];
                     cur_nxt.drv_low = 1'b1;
                     cur_nxt.got_ptr = 1'b0;
                     cur_nxt.upper = 1'b1;
                  end else begin
                     cur_nxt.st = ST_IDLE;
                  end
               end
            end
            ST_MCODE_NACK: begin
               // Stay released through the acknowledge clock, then wait for the restart.
               if (scl_rise) begin
                  cur_nxt.hs = 1'b1;
                  cur_nxt.st = ST_IDLE;
               end
            end
            ST_ADDR_ACK, ST_WR_ACK: begin
               if (scl_fall) begin
                  cur_nxt.cnt = 3'h0;
                  if (cur_r.is_rd) begin
                     cur_nxt.st = ST_RD;
                     cur_nxt.sh = cur_r.upper ? rd_data_i[15:8] : rd_data_i[7:0];
                     cur_nxt.drv_low = cur_r.upper ? !rd_data_i[15] : !rd_data_i[7];
                  end else begin
                     cur_nxt.st = ST_WR;
                     cur_nxt.drv_low = 1'b0;
                  end
               end
            end
            ST_WR: begin
               if (scl_rise) begin
                  cur_nxt.sh = {cur_r.sh[6:0], sda_v};
                  cur_nxt.cnt = cur_r.cnt + 3'h1;
                  cur_nxt.byte_done = (cur_r.cnt == ITP_LAST_BIT);
               end
               if (scl_fall && cur_r.byte_done) begin
                  cur_nxt.byte_done = 1'b0;
                  cur_nxt.st = ST_WR_ACK;
                  cur_nxt.drv_low = 1'b1;
                  if (!cur_r.got_ptr) begin
                     cur_nxt.ptr = cur_r.sh;
                     cur_nxt.got_ptr = 1'b1;
                  end else begin
                     cur_nxt.wr_v = 1'b1;
                     cur_nxt.wr_d = cur_r.sh;
                     cur_nxt.wr_up = cur_r.upper;
                     cur_nxt.upper = !cur_r.upper;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  cur_nxt.cnt = cur_r.cnt + 3'h1;
                  cur_nxt.sh = {cur_r.sh[6:0], 1'b0};
                  if (cur_r.cnt == ITP_LAST_BIT) begin
                     cur_nxt.st = ST_RD_ACK;
                     cur_nxt.drv_low = 1'b0;
                  end else begin
                     cur_nxt.drv_low = !cur_r.sh[6];
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  if (sda_v) begin
                     cur_nxt.st = ST_IDLE;
                  end else begin
                     cur_nxt.upper = !cur_r.upper;
                     cur_nxt.st = ST_WR_ACK;
                  end
               end
            end
            default: cur_nxt.st = ST_IDLE;
         endcase
      end
   end

   // State register.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur_r <= '{scl_s: 3'h7, sda_s: 3'h7, scl_q: 1'b1, sda_q: 1'b1, st: ST_IDLE,
                    upper: 1'b1, default: '0};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   itp_fifo #(.WIDTH(ITP_DATA_W), .DEPTH(ITP_FIFO_DEPTH)) u_fifo (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(cur_r.wr_v),
      .in_ready_o(fifo_ready),
      .in_data_i({cur_r.wr_d[7:1], cur_r.wr_d[0]}),
      .out_valid_o(fifo_out_v),
      .out_ready_i(!wr_valid_o || wr_ready_i),
      .out_data_o(fifo_data)
   );

   // Registered outputs.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         pointer_o <= 8'h00;
         wr_valid_o <= 1'b0;
         wr_data_o <= 8'h00;
         wr_upper_o <= 1'b0;
         rd_upper_o <= 1'b1;
         hs_mode_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         sda_oe_o <= cur_nxt.drv_low;
         pointer_o <= cur_nxt.ptr;
         // Output stage refills whenever it is empty or its word is taken.
         if (!wr_valid_o || wr_ready_i) begin
            wr_valid_o <= fifo_out_v;
            wr_data_o <= fifo_data;
         end
         wr_upper_o <= cur_nxt.upper;
         rd_upper_o <= cur_nxt.upper;
         hs_mode_o <= cur_nxt.hs;
         busy_o <= (cur_nxt.st != ST_IDLE);
      end
   end

   // Checks.
   a_nack_mcode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      cur_r.st == ST_MCODE_NACK |-> !cur_r.drv_low) else $error("master code driven");
   a_stop_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      stop_c |=> cur_r.st == ST_IDLE && !cur_r.hs) else $error("stop not idle");
   a_start_addr: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      start_c && !stop_c |=> cur_r.st == ST_ADDR) else $error("start missed");
   a_ack_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      cur_r.st == ST_ADDR_ACK |-> cur_r.drv_low) else $error("ack not driven");
   a_out_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !sda_o) else $error("data driven high");
   a_drive_change: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      $changed(cur_r.drv_low) && cur_r.st != ST_IDLE |-> !cur_r.scl_q)
      else $error("drive changed with clock high");
   a_hs_keep: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      cur_r.hs && start_c && !stop_c |=> cur_r.hs) else $error("hs lost");
   a_ptr_load: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      cur_r.st == ST_WR && !cur_r.got_ptr && scl_fall && cur_r.byte_done && !start_c &&
      !stop_c |=> cur_r.ptr == $past(cur_r.sh)) else $error("pointer not loaded");
   c_read: cover property (@(posedge sys_clk_i) cur_r.st == ST_RD_ACK);
   c_write: cover property (@(posedge sys_clk_i) cur_r.wr_v);
   c_hs: cover property (@(posedge sys_clk_i) cur_r.hs);
endmodule

// [tb/i2c_target_register_port_test.sv]
// Self-checking bench for the register port target and its write FIFO.
// Assumes the controller model drives the bus; the bench consumes writes.
`timescale 1ns/100ps
module i2c_target_register_port_test;
   import itp_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [1:0] sel_hi = 2'h0;
   logic [1:0] sel_lo = 2'h0;
   logic wr_ready_i = 1'b0;
   logic [15:0] rd_data_i = 16'h0000;
   logic scl, ctl_oe, sda_o, sda_oe_o, wr_valid_o, wr_upper_o, rd_upper_o, hs_mode_o, busy_o;
   logic [7:0] pointer_o, wr_data_o, ptr, b;
   logic [6:0] my_addr;
   logic ack_n;
   logic hold_rdy = 1'b0;
   logic [31:0] rnd_s = 32'h687b;
   logic [7:0] exp_q[$];
   int err_total = 0;
   int n_compared = 0;
   int cycles = 0;
   // Pull-up: the line is low only while some party enables its driver.
   wire logic sda = ~(ctl_oe | sda_oe_o);
   always #2.5 sys_clk_i = ~sys_clk_i;
   itp_target #(.VERSION(ITP_VER_TWO_SEL)) dut (
      .sys_clk_i, .reset_n_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
      .addr_select_high_i(sel_hi), .addr_select_low_i(sel_lo), .pointer_o,
      .wr_valid_o, .wr_ready_i, .wr_data_o, .wr_upper_o, .rd_data_i, .rd_upper_o,
      .hs_mode_o, .busy_o);
   itp_ctl_model ctl (.sda_i(sda), .scl_o(scl), .sda_oe_o(ctl_oe));
   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic rnd8(output logic [7:0] r);
      rnd_s = xs(rnd_s);
      r = rnd_s[7:0];
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Selection codes must be settled before release, as they are taken once.
   task automatic do_reset(input logic [1:0] h, input logic [1:0] l);
      reset_n_i = 1'b0;
      sel_hi = h;
      sel_lo = l;
      repeat (12) @(posedge sys_clk_i);
      #1 reset_n_i = 1'b1;
      repeat (4) @(posedge sys_clk_i);
   endtask
   // ==========================================================
   // Monitors
   // ==========================================================
   // Consumer with random stalls; also the run's cycle ceiling.
   always @(posedge sys_clk_i) begin
      cycles++;
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
         chk_val(wr_data_o, exp_q.size() ? exp_q.pop_front() : 8'hxx, "fifo byte");
      end
      if (sda_oe_o === 1'b1) chk_bit(sda_o, 1'b0, "pin driven high");
      if (cycles == 40000) begin
         err_total++;
         end_sim();
      end
      #1 wr_ready_i = ~hold_rdy & rnd_s[cycles[4:0]];
   end
   // The target may move the data line only while the clock is low.
   always @(sda_oe_o) if (reset_n_i === 1'b1) chk_bit(scl, 1'b0, "data moved");
   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      // Every selection code pair: near-miss refused, own address taken.
      for (int h = 0; h < 3; h++) for (int l = 0; l < 3; l++) begin
         do_reset(h[1:0], l[1:0]);
         chk_val({sda_oe_o, wr_valid_o, hs_mode_o, busy_o, rd_upper_o}, 16'h1, "reset");
         my_addr = {3'b101, h[1:0], l[1:0]};
         rnd8(b);
         ctl.start();
         ctl.wr_byte({my_addr ^ (7'h01 << (b % 7)), 1'b0}, ack_n);
         chk_bit(ack_n, 1'b1, "foreign address acked");
         ctl.wr_byte(b, ack_n);
         chk_bit(ack_n, 1'b1, "ignored byte acked");
         ctl.start();
         ctl.wr_byte({my_addr, 1'b0}, ack_n);
         chk_bit(ack_n, 1'b0, "own address");
         rnd8(ptr);
         ctl.wr_byte(ptr, ack_n);
         ctl.stop();
         chk_val(pointer_o, ptr, "pointer");
      end
      // Odd-length write with stalls, then a 16-byte burst that leaves the FIFO one word short of full.
      for (int n = 3; n <= 16; n += 13) begin
         hold_rdy = 1'b1;
         ctl.start();
         ctl.wr_byte({my_addr, 1'b0}, ack_n);
         rnd8(ptr);
         ctl.wr_byte(ptr, ack_n);
         chk_bit(ack_n, 1'b0, "pointer ack");
         for (int i = 0; i < n; i++) begin
            rnd8(b);
            exp_q.push_back(b);
            ctl.wr_byte(b, ack_n);
            chk_bit(ack_n, 1'b0, "data ack");
         end
         ctl.stop();
         chk_bit(wr_valid_o, 1'b1, "buffer holds data");
         hold_rdy = 1'b0;
         for (int i = 0; i < 800 && exp_q.size() > 0; i++) @(posedge sys_clk_i);
         repeat (3) @(posedge sys_clk_i);
         chk_bit(wr_valid_o, 1'b0, "buffer drained");
      end
      // Continuous read from the preset pointer, then a one-byte preset read.
      for (int n = 6; n >= 1; n -= 5) begin
         rnd_s = xs(rnd_s);
         rd_data_i = rnd_s[15:0];
         ctl.start();
         ctl.wr_byte({my_addr, 1'b1}, ack_n);
         chk_bit(ack_n, 1'b0, "read address");
         for (int k = 0; k < n; k++) begin
            ctl.rd_byte(k == n - 1, b);
            chk_val(b, k[0] ? rd_data_i[7:0] : rd_data_i[15:8], "read byte");
         end
         ctl.stop();
         repeat (10) @(posedge sys_clk_i);
         chk_val(pointer_o, ptr, "pointer kept");
         chk_bit(busy_o, 1'b0, "idle after stop");
      end
      // Master code, fast-mode transfers across repeated starts, then stop.
      rnd8(b);
      ctl.start();
      ctl.wr_byte({5'b00001, b[2:0]}, ack_n);
      chk_bit(ack_n, 1'b1, "master code acked");
      ctl.start();
      chk_bit(hs_mode_o, 1'b1, "fast mode entered");
      ctl.wr_byte({my_addr, 1'b1}, ack_n);
      chk_bit(ack_n, 1'b0, "fast address");
      ctl.rd_byte(1'b1, b);
      ctl.start();
      chk_bit(hs_mode_o, 1'b1, "fast mode kept");
      ctl.wr_byte({my_addr, 1'b1}, ack_n);
      ctl.rd_byte(1'b1, b);
      chk_val(b, rd_data_i[15:8], "fast read");
      ctl.stop();
      repeat (10) @(posedge sys_clk_i);
      chk_bit(hs_mode_o, 1'b0, "fast mode left");
      end_sim();
   end
endmodule

// [tb/itp_ctl_model.sv]
// Behavioural bus controller that clocks the target and moves bytes.
// Assumes the bench resolves the pulled-up data line from both enables.
`timescale 1ns/100ps
module itp_ctl_model (
   // Bus lines.
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // A quarter of the 125 ns bus period.
   localparam real Q = 31.25;
   // The clock stands high between frames.
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // ==========================================================
   // Conditions and bits
   // ==========================================================
   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      sda_oe_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      #Q;
      sda_oe_o = 1'b1;
      #Q;
      scl_o = 1'b0;
      #Q;
   endtask
   // Stop: data rises while the clock is high, then the bus idles.
   task automatic stop();
      sda_oe_o = 1'b1;
      #Q;
      scl_o = 1'b1;
      #Q;
      sda_oe_o = 1'b0;
      #(2 * Q);
   endtask
   // Data changes only a quarter period after the clock fell.
   task automatic put_bit(input logic b);
      sda_oe_o = ~b;
      #Q;
      scl_o = 1'b1;
      #(2 * Q);
      scl_o = 1'b0;
      #Q;
   endtask
   // The line is released so the target may drive it.
   task automatic get_bit(output logic b);
      sda_oe_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      #Q;
      b = sda_i;
      #Q;
      scl_o = 1'b0;
      #Q;
   endtask
   // ==========================================================
   // Bytes
   // ==========================================================
   // Eight bits, first bit foremost, then the target's answer bit.
   task automatic wr_byte(input logic [7:0] d, output logic ack_n);
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(ack_n);
   endtask
   // The final answer bit decides whether the target keeps sending.
   task automatic rd_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(last);
   endtask
endmodule
